// ===== hpcf_pkg.sv
// Package for the host port control and flag block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package hpcf_pkg;
   localparam logic [15:0] HPCF_PORT_CTRL_ADDR  = 16'hffc4;
   localparam logic [15:0] HPCF_STATUS_ADDR     = 16'hffc6;
   localparam logic [15:0] HPCF_HOSTCTL_ADDR    = 16'hffcc;
   localparam logic [15:0] HPCF_PORT_CTRL_RESET = 16'h0000;
   localparam logic [15:0] HPCF_PORT_CTRL_MASK  = 16'hff7f;
   localparam int HPCF_GPIO_EN_BIT    = 0;
   localparam int HPCF_A8_EN_BIT      = 1;
   localparam int HPCF_A9_EN_BIT      = 2;
   localparam int HPCF_CS_EN_BIT      = 3;
   localparam int HPCF_REQ_EN_BIT     = 4;
   localparam int HPCF_ACK_EN_BIT     = 5;
   localparam int HPCF_PORT_EN_BIT    = 6;
   localparam int HPCF_REQ_OD_BIT     = 8;
   localparam int HPCF_DS_POL_BIT     = 9;
   localparam int HPCF_AS_POL_BIT     = 10;
   localparam int HPCF_MUX_BIT        = 11;
   localparam int HPCF_DUAL_DS_BIT    = 12;
   localparam int HPCF_CS_POL_BIT     = 13;
   localparam int HPCF_REQ_POL_BIT    = 14;
   localparam int HPCF_ACK_POL_BIT    = 15;
   localparam int HPCF_ST_PEND_BIT    = 2;
   localparam int HPCF_ST_FLAG_A_BIT  = 3;
   localparam int HPCF_ST_FLAG_B_BIT  = 4;
   localparam int HPCF_HC_REQ_BIT     = 0;
   localparam int HPCF_HC_DRQ_BIT     = 1;
endpackage

// ===== hpcf_pin_mux.sv
// Pin function, direction and polarity decode for the shared host pins.
// Assumes a registered control word; all outputs are combinational.
`timescale 1ns/1ps
module hpcf_pin_mux
   import hpcf_pkg::*;
(
   input  wire logic [15:0] ctrl,
   input  wire logic        drq,
   input  wire logic        req_act,
   input  wire logic        txreq_act,
   input  wire logic        rxreq_act,
   input  wire logic        ack_raw,
   input  wire logic        ds_raw,
   input  wire logic        as_raw,
   input  wire logic        cs_raw,
   output logic      [6:0]  host_fn,
   output logic             req_o,
   output logic             req_oe,
   output logic             rrq_o,
   output logic             rrq_oe,
   output logic             ack_active,
   output logic             ds_active,
   output logic             as_active,
   output logic             cs_active
);
   wire en   = ctrl[HPCF_PORT_EN_BIT];
   wire mux  = ctrl[HPCF_MUX_BIT];
   wire ren  = en & ctrl[HPCF_REQ_EN_BIT];
   wire od   = ctrl[HPCF_REQ_OD_BIT];
   wire rpol = ctrl[HPCF_REQ_POL_BIT];
   wire f_a8  = en & mux & ctrl[HPCF_A8_EN_BIT];                  // R8
   wire f_a9  = en & mux & ctrl[HPCF_A9_EN_BIT];                  // R9
   wire f_cs  = en & ~mux & ctrl[HPCF_CS_EN_BIT];                 // R10
   wire f_a10 = en & mux & ctrl[HPCF_CS_EN_BIT];                  // R10
   wire f_req = ren;                                              // R11
   wire f_rrq = ren & drq;                                        // R11
   wire f_ack = ren & ~drq & ctrl[HPCF_ACK_EN_BIT];               // R12
   assign host_fn = {f_ack, f_rrq, f_req, f_a10, f_cs, f_a9, f_a8}; // R13

   function automatic logic [1:0] drive(input logic act);
      logic lvl;
      lvl = act ~^ rpol;                                          // R21
      drive = od ? {1'b0, ~lvl} : {lvl, 1'b1};                    // R15
   endfunction

   wire [1:0] dq = drive(drq ? txreq_act : req_act);
   wire [1:0] dr = drive(rxreq_act);
   assign req_o  = f_req & dq[1];
   assign req_oe = f_req & dq[0];
   assign rrq_o  = f_rrq & dr[1];
   assign rrq_oe = f_rrq & dr[0];
   assign ack_active = f_ack & (ack_raw ~^ ctrl[HPCF_ACK_POL_BIT]); // R22
   assign ds_active  = en & (ds_raw ~^ ctrl[HPCF_DS_POL_BIT]);      // R16
   assign as_active  = en & mux & (as_raw ~^ ctrl[HPCF_AS_POL_BIT]);// R17
   assign cs_active  = en & ~mux & f_cs & (cs_raw ~^ ctrl[HPCF_CS_POL_BIT]); // R20
endmodule // hpcf_pin_mux

// ===== hpcf_top.sv
// Control and status part of the parallel host port: APB registers,
// host command pending, host flags and pin configuration.
// Assumes host-side events are synchronous to CLK_SYS.
`timescale 1ns/1ps
// Functional notes
// R1: Pending flag in status bit 2 sets when host sets command request.
// R2: Core service clears request and pending; host clear clears pending.
// R3: Status bits 3 and 4 mirror the two host-to-DSP flags.
// R4: Status bits 5 to 15 read zero.
// R5: Reset clears pending, both flags and the whole control register.
// R6: Software changes configuration only with port disabled, enable last.
// R7: Bit 0 connects GPIO pins; clear tri-states and isolates them.
// R8: Bit 1 makes shared pin address line 8 in muxed mode.
// R9: Bit 2 makes shared pin address line 9 in muxed mode.
// R10: Bit 3 gives chip select unmuxed, address line 10 muxed.
// R11: Bit 4 enables request outputs, single or transmit plus receive.
// R12: Acknowledge input needs bits 5 and 4 in single-request mode.
// R13: Bit 6 enables host interface; clear makes all pins GPIO.
// R14: Control bit 7 is reserved and reads zero.
// R15: Bit 8 makes enabled request pins open drain.
// R16: Bit 9 selects data strobe polarity.
// R17: Bit 10 selects address strobe polarity.
// R18: Bit 11 takes address from latched muxed bus, else pins.
// R19: Bit 12 selects dual strobes, else strobe plus direction.
// R20: Bit 13 selects chip select polarity.
// R21: Bit 14 selects request output polarity.
// R22: Bit 15 sets acknowledge polarity; acknowledge drives vector onto bus.
// R23: Pin selections follow the control register from the next cycle.
module hpcf_top
   import hpcf_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input  wire logic              CLK_SYS,
   input  wire logic              RESET,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              CMD_SET,
   input  wire logic              CMD_CLEAR,
   input  wire logic              CMD_SERVICED,
   input  wire logic              FLAG_A_IN,
   input  wire logic              FLAG_B_IN,
   input  wire logic              DRQ_IN,
   input  wire logic              REQ_ACTIVE,
   input  wire logic              TXREQ_ACTIVE,
   input  wire logic              RXREQ_ACTIVE,
   input  wire logic              ACK_PIN,
   input  wire logic              DS_PIN,
   input  wire logic              RW_PIN,
   input  wire logic              AS_PIN,
   input  wire logic              CS_PIN,
   input  wire logic [10:0]       ADDR_PINS,
   input  wire logic [7:0]        AD_PINS,
   input  wire logic [7:0]        VECTOR,
   input  wire logic [15:0]       GPIO_OUT_RAW,
   input  wire logic [15:0]       GPIO_OE_RAW,
   input  wire logic [15:0]       GPIO_IN_RAW,
   output logic      [15:0]       GPIO_OUT,
   output logic      [15:0]       GPIO_OE,
   output logic      [15:0]       GPIO_IN,
   output logic                   CMD_REQ,
   output logic                   CMD_PENDING,
   output logic      [6:0]        HOST_FN,
   output logic                   REQ_O,
   output logic                   REQ_OE,
   output logic                   RRQ_O,
   output logic                   RRQ_OE,
   output logic                   ACK_ACTIVE,
   output logic                   VECTOR_OE,
   output logic      [7:0]        VECTOR_OUT,
   output logic                   READ_STB,
   output logic                   WRITE_STB,
   output logic                   CS_ACTIVE,
   output logic      [10:0]       HOST_ADDR
);
   // The register decode compares the low 16 address bits.
   if (ADDR_W < 16) begin : g_addr_w_chk
      $error("hpcf_top: ADDR_W must be at least 16");
   end

   logic [15:0] ctrl_q,  ctrl_d;
   logic        hc_q,    hc_d;
   logic        pend_q,  pend_d;
   logic        fa_q,    fb_q;
   logic        drq_q;
   logic [10:0] alat_q;
   logic [7:0]  vec_q;
   wire         as_act;
   wire         ds_act;
   wire  [6:0]  fn;

   // APB: zero wait state, unmapped addresses return an error.
   wire [15:0] word_addr = PADDR[15:0];
   wire acc       = PSEL & PENABLE;
   wire hit_ctrl  = (word_addr == HPCF_PORT_CTRL_ADDR);
   wire hit_stat  = (word_addr == HPCF_STATUS_ADDR);
   wire hit_hctl  = (word_addr == HPCF_HOSTCTL_ADDR);
   wire mapped    = hit_ctrl | hit_stat | hit_hctl;
   wire wr_ctrl   = acc & PWRITE & hit_ctrl;
   assign PREADY  = 1'b1;
   assign PSLVERR = acc & ~mapped;

   // Bit 7 is masked so it can never hold a one.
   assign ctrl_d = wr_ctrl ? (PWDATA[15:0] & HPCF_PORT_CTRL_MASK) // R14
                           : ctrl_q;                            // R23

   // Host set wins over any clear arriving in the same cycle.
   assign hc_d   = CMD_SET | (hc_q & ~CMD_CLEAR & ~CMD_SERVICED); // R2
   assign pend_d = hc_d;                                          // R1

   wire [15:0] status_w = {11'h000, fb_q, fa_q, pend_q, 2'b00};  // R3 R4
   wire [15:0] hctl_w   = {14'h0000, drq_q, hc_q};
   wire [15:0] rd_mux   = hit_ctrl ? ctrl_q :
                          hit_stat ? status_w :
                          hit_hctl ? hctl_w : 16'h0000;

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         ctrl_q <= HPCF_PORT_CTRL_RESET;                          // R5
         hc_q   <= 1'b0;
         pend_q <= 1'b0;                                          // R5
         fa_q   <= 1'b0;                                          // R5
         fb_q   <= 1'b0;                                          // R5
         drq_q  <= 1'b0;
         PRDATA <= 32'h00000000;
         alat_q <= 11'h000;
         vec_q  <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         hc_q   <= hc_d;
         pend_q <= pend_d;
         fa_q   <= FLAG_A_IN;                                     // R3
         fb_q   <= FLAG_B_IN;                                     // R3
         drq_q  <= DRQ_IN;
         PRDATA <= (PSEL & ~PENABLE & ~PWRITE) ? {16'h0000, rd_mux}
                                               : PRDATA;
         if (as_act)
            alat_q <= {ADDR_PINS[10:8], AD_PINS};                 // R18
         vec_q  <= VECTOR;
      end
   end

   hpcf_pin_mux u_mux (
      .ctrl       (ctrl_q),
      .drq        (drq_q),
      .req_act    (REQ_ACTIVE),
      .txreq_act  (TXREQ_ACTIVE),
      .rxreq_act  (RXREQ_ACTIVE),
      .ack_raw    (ACK_PIN),
      .ds_raw     (DS_PIN),
      .as_raw     (AS_PIN),
      .cs_raw     (CS_PIN),
      .host_fn    (fn),
      .req_o      (REQ_O),
      .req_oe     (REQ_OE),
      .rrq_o      (RRQ_O),
      .rrq_oe     (RRQ_OE),
      .ack_active (ACK_ACTIVE),
      .ds_active  (ds_act),
      .as_active  (as_act),
      .cs_active  (CS_ACTIVE)
   );

   assign HOST_FN     = fn;
   assign CMD_REQ     = hc_q;
   assign CMD_PENDING = pend_q;
   assign VECTOR_OE   = ACK_ACTIVE;                               // R22
   assign VECTOR_OUT  = vec_q;                                    // R22

   // Dual mode: data strobe pin is write, direction pin is read strobe.
   wire rw_act = ctrl_q[HPCF_PORT_EN_BIT] &
                 (RW_PIN ~^ ctrl_q[HPCF_DS_POL_BIT]);
   wire dual   = ctrl_q[HPCF_DUAL_DS_BIT];
   assign READ_STB  = dual ? rw_act : (ds_act & RW_PIN);          // R19
   assign WRITE_STB = dual ? ds_act : (ds_act & ~RW_PIN);         // R19

   assign HOST_ADDR = ctrl_q[HPCF_MUX_BIT] ? alat_q : ADDR_PINS;  // R18

   // A pin is GPIO when no host function owns it; bit 0 gates GPIO.
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_gpio
         wire owned;
         if (g < 7) begin : g_fn
            assign owned = fn[g];                                  // R13
         end else begin : g_bus
            assign owned = ctrl_q[HPCF_PORT_EN_BIT];               // R13
         end
         wire live  = ~owned & ctrl_q[HPCF_GPIO_EN_BIT];           // R7
         assign GPIO_OUT[g] = live & GPIO_OUT_RAW[g];
         assign GPIO_OE[g]  = live & GPIO_OE_RAW[g];
         assign GPIO_IN[g]  = live & GPIO_IN_RAW[g];
      end
   endgenerate
endmodule // hpcf_top

// ===== hpcf_asserts.sv
// Checker for the host port control block, bound to its top module.
// Assumes one clock and the synchronous active high reset.
`timescale 1ns/1ps
module hpcf_asserts
   import hpcf_pkg::*;
#(parameter int ADDR_W = 16) (
   input wire logic              CLK_SYS,
   input wire logic              RESET,
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic              PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0]       PWDATA,
   input wire logic [31:0]       PRDATA,
   input wire logic              PSLVERR,
   input wire logic              CMD_SET,
   input wire logic              CMD_SERVICED,
   input wire logic              CMD_REQ,
   input wire logic              CMD_PENDING,
   input wire logic [6:0]        HOST_FN,
   input wire logic              REQ_O,
   input wire logic              REQ_OE,
   input wire logic              ACK_ACTIVE
);
   logic [15:0] ctl_q;
   wire  [15:0] adr  = PADDR[15:0];
   wire         rd_s = PSEL && !PENABLE && !PWRITE;
   wire         hit  = adr inside {HPCF_PORT_CTRL_ADDR, HPCF_STATUS_ADDR,
                                   HPCF_HOSTCTL_ADDR};
   // Shadow control word; it changes on the same edge as the design's.
   always_ff @(posedge CLK_SYS)
      if (RESET) ctl_q <= 16'h0000;
      else if (PSEL && PENABLE && PWRITE && adr == HPCF_PORT_CTRL_ADDR)
         ctl_q <= PWDATA[15:0] & HPCF_PORT_CTRL_MASK;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   pend_set_a: assert property (CMD_SET |=> CMD_PENDING && CMD_REQ)
      else $error("pending flag not set");
   pend_svc_a: assert property (CMD_SERVICED && !CMD_SET |=> !CMD_PENDING && !CMD_REQ)
      else $error("service left command pending");
   st_resv_a: assert property (rd_s && adr == HPCF_STATUS_ADDR |=> PRDATA[31:5] == 27'h0)
      else $error("status reserved bits set");
   ctl_rd_a: assert property (rd_s && adr == HPCF_PORT_CTRL_ADDR |=> PRDATA == {16'h0, ctl_q})
      else $error("control read value wrong");
   bad_addr_a: assert property (PSEL && PENABLE && !hit |-> PSLVERR)
      else $error("unmapped access not refused");
   rst_clear_a: assert property (disable iff (1'h0) RESET |=> !CMD_PENDING && HOST_FN == 7'h00)
      else $error("reset left state set");
   req_oe_a: assert property (REQ_OE |-> ctl_q[4] && ctl_q[6])
      else $error("request pin driven while disabled");
   od_low_a: assert property (REQ_OE && ctl_q[8] |-> !REQ_O)
      else $error("open drain request driven high");
   ack_en_a: assert property (ACK_ACTIVE |-> ctl_q[4] && ctl_q[5] && ctl_q[6])
      else $error("acknowledge active while disabled");
   fn_off_a: assert property (!ctl_q[6] |-> HOST_FN == 7'h00)
      else $error("host function with port disabled");
   cover property (CMD_SET);
   cover property (REQ_OE && ctl_q[8]);
   cover property (PSLVERR);
endmodule // hpcf_asserts
bind hpcf_top hpcf_asserts #(.ADDR_W(ADDR_W)) hpcf_asserts_i (.*);

// ===== hpcf_host_model.sv
// Model of the external host: command, flags and host pin levels.
// Assumes the bench calls its tasks between clock edges.
`timescale 1ns/1ps
module hpcf_host_model (
   input  wire logic        CLK_SYS,
   output logic             CMD_SET,
   output logic             CMD_CLEAR,
   output logic             FLAG_A_IN,
   output logic             FLAG_B_IN,
   output logic             DRQ_IN,
   output logic      [31:0] PINS
);
   initial {CMD_SET, CMD_CLEAR, FLAG_A_IN, FLAG_B_IN, DRQ_IN, PINS} = 37'h0;
   // Strobes, select and acknowledge take a new random level every cycle, so may sit idle.
   always @(posedge CLK_SYS) PINS <= $urandom;
   task automatic cmd(input logic set);
      @(posedge CLK_SYS);
      if (set) CMD_SET <= 1'h1;
      else CMD_CLEAR <= 1'h1;
      @(posedge CLK_SYS);
      {CMD_SET, CMD_CLEAR} <= 2'h0;
   endtask
   task automatic flags(input logic [2:0] v);
      @(posedge CLK_SYS);
      {DRQ_IN, FLAG_B_IN, FLAG_A_IN} <= v;
   endtask
endmodule // hpcf_host_model

// ===== tb.sv
// Self-checking bench for the host port control block.
// Assumes the host model drives the host pins, flags and commands.
`timescale 1ns/1ps
module tb;
   import hpcf_pkg::*;
   logic        CLK_SYS = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic        CMD_SERVICED = 0, REQ_ACTIVE = 0, TXREQ_ACTIVE = 0;
   logic        RXREQ_ACTIVE = 0, e, s, pend = 0;
   logic [15:0] PADDR = 16'h0, c = 16'h0, own;
   logic [6:0]  f;
   logic [7:0]  vprev = 8'h0;
   logic [31:0] PWDATA = 32'h0, q, d;
   logic [47:0] gp = 48'h0;
   int          failures = 0, checks_done = 0;
   wire         CMD_SET, CMD_CLEAR, FLAG_A_IN, FLAG_B_IN, DRQ_IN;
   wire  [31:0] PINS, PRDATA;
   wire  [15:0] GPIO_OUT, GPIO_OE, GPIO_IN, GPIO_OUT_RAW = gp[15:0];
   wire  [15:0] GPIO_OE_RAW = gp[31:16], GPIO_IN_RAW = gp[47:32];
   wire  [10:0] ADDR_PINS = PINS[15:5], HOST_ADDR;
   wire  [7:0]  AD_PINS = PINS[23:16], VECTOR = PINS[31:24], VECTOR_OUT;
   wire  [6:0]  HOST_FN;
   wire         ACK_PIN = PINS[0], DS_PIN = PINS[1], RW_PIN = PINS[2];
   wire         AS_PIN = PINS[3], CS_PIN = PINS[4];
   wire         PREADY, PSLVERR, CMD_REQ, CMD_PENDING, REQ_O, REQ_OE, RRQ_O;
   wire         RRQ_OE, ACK_ACTIVE, VECTOR_OE, READ_STB, WRITE_STB, CS_ACTIVE;
   hpcf_top hpcf_top_i (.*);
   hpcf_host_model hpcf_host_model_i (.*);
   always #50 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) gp <= {16'($urandom), $urandom};
   // The vector output is registered, so it trails the vector by one edge.
   always @(posedge CLK_SYS) vprev <= VECTOR;
   task automatic stop_test();
      if (failures == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n = 0;
      @(posedge CLK_SYS);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLK_SYS);
      PENABLE <= 1'h1;
      do @(posedge CLK_SYS);
      while (PREADY !== 1'h1 && ++n < 20);
      if (n >= 20) begin
         failures++;
         stop_test();
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
   endtask
   // Expected {enable, level} of a request pin; an open-drain pin only
   // pulls low, so it is enabled when the level it would drive is low.
   function automatic logic [1:0] req_exp(input logic [15:0] k,
                                          input logic on, input logic a);
      if (!(on && k[4] && k[6])) return 2'h0;
      return k[8] ? {a ^ k[14], 1'h0} : {1'h1, k[14] == a};
   endfunction
   // Expected pin functions in the order A8, A9, CS, A10, REQ, RRQ, ACK.
   function automatic logic [6:0] fn_exp(input logic [15:0] k,
                                         input logic dq);
      logic en, rq;
      en = k[6];
      rq = en & k[4];
      return {rq & ~dq & k[5], rq & dq, rq, en & k[11] & k[3],
              en & ~k[11] & k[3], en & k[11] & k[2], en & k[11] & k[1]};
   endfunction
   initial begin
      void'($urandom(29496));
      repeat (8) @(posedge CLK_SYS);
      RESET <= 1'h0;
      apb(1'h0, HPCF_PORT_CTRL_ADDR, 32'h0, q, e);
      chk(q, 32'h0);
      apb(1'h1, 16'hffd0, 32'hffff, q, e);
      chk(32'(e), 32'h1);
      repeat (40) begin
         d = $urandom;
         REQ_ACTIVE <= d[19];
         TXREQ_ACTIVE <= d[20];
         RXREQ_ACTIVE <= d[21];
         hpcf_host_model_i.flags(d[18:16]);
         case (d[23:22])
            2'h1: hpcf_host_model_i.cmd(1'h1);
            2'h2: hpcf_host_model_i.cmd(1'h0);
            2'h3: begin
               @(posedge CLK_SYS);
               CMD_SERVICED <= 1'h1;
               @(posedge CLK_SYS);
               CMD_SERVICED <= 1'h0;
            end
            default: ;
         endcase
         pend = d[23:22] == 2'h1 || (pend && d[23:22] == 2'h0);
         // Disable first, configure, then enable last.
         apb(1'h1, HPCF_PORT_CTRL_ADDR, {16'h0, c & 16'hffbf}, q, e);
         apb(1'h1, HPCF_PORT_CTRL_ADDR, d & 32'hffbf, q, e);
         apb(1'h1, HPCF_PORT_CTRL_ADDR, d, q, e);
         c = d[15:0];
         apb(1'h0, HPCF_PORT_CTRL_ADDR, 32'h0, q, e);
         chk(q, {16'h0, c & HPCF_PORT_CTRL_MASK});
         apb(1'h0, HPCF_STATUS_ADDR, 32'h0, q, e);
         chk(q, {27'h0, d[17:16], pend, 2'h0});
         apb(1'h0, HPCF_HOSTCTL_ADDR, 32'h0, q, e);
         chk(q, {30'h0, d[18], pend});
         @(negedge CLK_SYS);
         f = fn_exp(c, d[18]);
         own = {{9{c[6]}}, f};
         s = c[6] & (DS_PIN == c[9]);
         chk(32'({REQ_OE, REQ_O & REQ_OE}),
             32'(req_exp(c, 1'h1, d[18] ? d[20] : d[19])));
         chk(32'({RRQ_OE, RRQ_O & RRQ_OE}),
             32'(req_exp(c, d[18], d[21])));
         chk(32'(HOST_FN), 32'(f));
         chk(32'({CMD_REQ, CMD_PENDING}), 32'({2{pend}}));
         chk(32'({ACK_ACTIVE, VECTOR_OE}),
             32'({2{f[6] & (ACK_PIN == c[15])}}));
         chk(32'(VECTOR_OUT), 32'(vprev));
         chk(32'(CS_ACTIVE),
             32'(c[6] & ~c[11] & c[3] & (CS_PIN == c[13])));
         chk(32'({READ_STB, WRITE_STB}),
             c[12] ? 32'({c[6] & (RW_PIN == c[9]), s})
                   : 32'({s & RW_PIN, s & ~RW_PIN}));
         chk(32'(GPIO_OE), 32'(GPIO_OE_RAW & ~own & {16{c[0]}}));
         chk(32'(GPIO_IN), 32'(GPIO_IN_RAW & ~own & {16{c[0]}}));
         if (!c[11])
            chk(32'(HOST_ADDR), 32'(ADDR_PINS));
         // Return to the rising edge so the next stimulus lands there.
         @(posedge CLK_SYS);
      end
      stop_test();
   end
endmodule // tb
